// file: src/sgd_regs.svh
// Register offsets, fields, reset values and timing counts
`ifndef SGD_REGS_SVH
`define SGD_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SGD_OFF_CLK_LOW      8'h0C
`define SGD_OFF_GPIO_ROUTE   8'h0D
`define SGD_OFF_GPIO_DIR     8'h0E
`define SGD_OFF_RSVD_A       8'h0F
`define SGD_OFF_VP_CFG       8'h10
`define SGD_OFF_VP_MATCH     8'h11
`define SGD_OFF_RSVD_B       8'h12

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SGD_RST_CLK_LOW      8'h7F
`define SGD_RST_GPIO_ROUTE   8'hF0
`define SGD_RST_GPIO_DIR     8'h0F
`define SGD_RST_RSVD_A       4'h0
`define SGD_RST_VP_CFG       8'h00
`define SGD_RST_VP_MATCH     8'h00
`define SGD_RST_RSVD_B       8'h00
`define SGD_RD_UNMAPPED      8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SGD_ROUTE_HI         7
`define SGD_ROUTE_LO         4
`define SGD_LEVEL_HI         3
`define SGD_LEVEL_LO         0
`define SGD_DRIVE_HI         7
`define SGD_DRIVE_LO         4
`define SGD_SENSE_HI         3
`define SGD_SENSE_LO         0
`define SGD_RSVD_A_HI        3
`define SGD_VP_ANY_BIT       4
`define SGD_VP_MATCH_BIT     3
`define SGD_VP_YUV_BIT       2
`define SGD_VP_FV_BIT        1
`define SGD_VP_LV_BIT        0
`define SGD_MATCH_HI         5

// ----------------------------------------
// Timing and packet types
// ----------------------------------------
`define SGD_OSC_PERIOD_PS    38095
`define SGD_CLK_LOW_EXTRA    9'h005
`define SGD_DT_YUV10_A       6'h19
`define SGD_DT_YUV10_B       6'h1D
`define SGD_DT_YUV10_C       6'h1F

`endif

// file: src/sgd_pkg.sv
// Types shared by the configuration bank
package sgd_pkg;

	// ----------------------------------------
	// Register access request
	// ----------------------------------------
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sgd_reg_req_s;

	// ----------------------------------------
	// Video port packet header
	// ----------------------------------------
	typedef struct packed {
		logic       valid;
		logic [5:0] dataType;
	} sgd_pkt_s;

	typedef enum logic [0:0] {
		TMR_IDLE  = 1'b0,
		TMR_COUNT = 1'b1
	} sgd_tmr_state_e;

	// Long data type test
	function automatic logic sgd_is_long(input logic [5:0] dt);
		sgd_is_long = dt[5] | dt[4];
	endfunction

endpackage

// file: src/sgd_low_timer.sv
// Low period timer: programmed count plus fixed extra periods
`timescale 1ns/1ps
module sgd_low_timer (
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic       start,
	input  wire logic [7:0] lowCount,
	output logic            busy,
	output logic            done
);
	`include "sgd_regs.svh"

	sgd_pkg::sgd_tmr_state_e state;
	logic [8:0]              cnt;
	wire  [8:0]              total;
	wire                     lastTick;

	// [R02] Count plus five
	assign total    = {1'b0, lowCount} + `SGD_CLK_LOW_EXTRA - 9'h001;
	assign lastTick = (cnt == 9'h000);

	// [R01] Low width count
	always_ff @(posedge clk) begin
		if (!nrst) begin
			state <= sgd_pkg::TMR_IDLE;
			cnt   <= 9'h000;
			busy  <= 1'b0;
			done  <= 1'b0;
		end else begin
			done <= 1'b0;
			case (state)
				sgd_pkg::TMR_IDLE: begin
					if (start) begin
						cnt   <= total;
						busy  <= 1'b1;
						state <= sgd_pkg::TMR_COUNT;
					end
				end
				sgd_pkg::TMR_COUNT: begin
					if (lastTick) begin
						busy  <= 1'b0;
						done  <= 1'b1;
						state <= sgd_pkg::TMR_IDLE;
					end else begin
						cnt <= cnt - 9'h001;
					end
				end
				default: begin
					state <= sgd_pkg::TMR_IDLE;
				end
			endcase
		end
	end
endmodule

// file: src/sgd_pkt_filter.sv
// Video port packet filter and sync polarity
`timescale 1ns/1ps
module sgd_pkt_filter (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  sgd_pkg::sgd_pkt_s     pktIn,
	input  wire logic             rate100mhzSel,
	input  wire logic             frameValidIn,
	input  wire logic             lineValidIn,
	input  wire logic             passAllLongTypes,
	input  wire logic             typeMatchEn,
	input  wire logic             passYuv10Types,
	input  wire logic             frameValidInvert,
	input  wire logic             lineValidInvert,
	input  wire logic [5:0]       typeMatchValue,
	output sgd_pkg::sgd_pkt_s     pktOut,
	output logic                  pktPass,
	output logic                  frameValid,
	output logic                  lineValid
);
	`include "sgd_regs.svh"

	wire anyHit;
	wire matchHit;
	wire yuvType;
	wire yuvHit;
	wire passNow;

	// [R09] Any long type
	assign anyHit   = passAllLongTypes & sgd_pkg::sgd_is_long(pktIn.dataType);
	// [R14] [R15] Long value match
	assign matchHit = typeMatchEn & sgd_pkg::sgd_is_long(typeMatchValue)
		& (pktIn.dataType == typeMatchValue);
	assign yuvType  = (pktIn.dataType == `SGD_DT_YUV10_A)
		| (pktIn.dataType == `SGD_DT_YUV10_B)
		| (pktIn.dataType == `SGD_DT_YUV10_C);
	// [R11] YUV in fast mode
	assign yuvHit   = passYuv10Types & rate100mhzSel & yuvType;
	// [R10] Match enable
	assign passNow  = pktIn.valid & (anyHit | matchHit | yuvHit);

	always_ff @(posedge clk) begin
		if (!nrst) begin
			pktOut     <= '0;
			pktPass    <= 1'b0;
			frameValid <= 1'b0;
			lineValid  <= 1'b0;
		end else begin
			pktOut     <= pktIn;
			pktPass    <= passNow;
			// [R12] Frame polarity
			frameValid <= frameValidIn ^ frameValidInvert;
			// [R13] Line polarity
			lineValid  <= lineValidIn ^ lineValidInvert;
		end
	end
endmodule

// file: src/sgd_cfg_bank.sv
// Configuration bank: clock low time, pin routing, packet filter
//
// Contract
// [R01] The clock low register sets the low width of the driven clock in oscillator periods.
// [R02] The real low period is the programmed count plus five periods.
// [R03] The same value sets how long target data is presented before clock release.
// [R04] The clock low register resets to 0x7F.
// [R05] Routing bits 7:4 put remote pin data on local pins 3..0 and reset to 0xF.
// [R06] Level bits 3:0 set the pin level when routing is off and drive is on.
// [R07] Bits 7:4 of the direction register enable pin drivers, reset off.
// [R08] Bits 3:0 of the direction register enable pin inputs, reset on.
// [R09] Config bit 4 passes every long data type packet, reset 0.
// [R10] Config bit 3 passes matching types and blocks writes to the match value.
// [R11] Config bit 2 with the fast mode passes the YUV 10-bit types 0x19, 0x1D, 0x1F.
// [R12] Config bit 1 inverts frame valid.
// [R13] Config bit 0 inverts line valid.
// [R14] Matching uses bits 5:0 of the match value in either rate mode.
// [R15] A match only happens when the match value is a long type.
// [R16] A pin with drive and routing off is left undriven.
`timescale 1ns/1ps
module sgd_cfg_bank (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  sgd_pkg::sgd_reg_req_s regReq,
	output logic [7:0]            regRdData,
	output logic                  regRdValid,
	input  wire logic             sclLowStart,
	output logic                  sclLowBusy,
	output logic                  sclLowDone,
	input  wire logic             sdaSetupStart,
	output logic                  sdaSetupBusy,
	output logic                  sdaSetupDone,
	input  wire logic [3:0]       remoteGpio,
	input  wire logic [3:0]       gpioIn,
	output logic [3:0]            gpioOut,
	output logic [3:0]            gpioOe,
	output logic [3:0]            gpioSense,
	input  sgd_pkg::sgd_pkt_s     pktIn,
	input  wire logic             rate100mhzSel,
	input  wire logic             rate75mhzSel,
	input  wire logic             frameValidIn,
	input  wire logic             lineValidIn,
	output sgd_pkg::sgd_pkt_s     pktOut,
	output logic                  pktPass,
	output logic                  frameValid,
	output logic                  lineValid
);
	`include "sgd_regs.svh"

	// ----------------------------------------
	// Register storage
	// ----------------------------------------
	logic [7:0] i2cClockLowPeriod;
	logic [7:0] gpioOutputRouting;
	logic [7:0] gpioPinDirection;
	logic [3:0] reservedSlotA;
	logic [7:0] videoPortFilterConfig;
	logic [7:0] videoPortTypeMatch;
	logic [7:0] reservedSlotB;

	// ----------------------------------------
	// Offset compare
	// ----------------------------------------
	function automatic logic addrIs(input logic [7:0] addr, input logic [7:0] offset);
		addrIs = (addr == offset);
	endfunction

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	wire        hitClkLow;
	wire        hitRoute;
	wire        hitDir;
	wire        hitRsvdA;
	wire        hitCfg;
	wire        hitMatch;
	wire        hitRsvdB;
	wire        wrClkLow;
	wire        wrRoute;
	wire        wrDir;
	wire        wrRsvdA;
	wire        wrCfg;
	wire        wrMatch;
	wire        wrRsvdB;
	wire [7:0]  rdMux;

	assign hitClkLow = addrIs(regReq.addr, `SGD_OFF_CLK_LOW);
	assign hitRoute  = addrIs(regReq.addr, `SGD_OFF_GPIO_ROUTE);
	assign hitDir    = addrIs(regReq.addr, `SGD_OFF_GPIO_DIR);
	assign hitRsvdA  = addrIs(regReq.addr, `SGD_OFF_RSVD_A);
	assign hitCfg    = addrIs(regReq.addr, `SGD_OFF_VP_CFG);
	assign hitMatch  = addrIs(regReq.addr, `SGD_OFF_VP_MATCH);
	assign hitRsvdB  = addrIs(regReq.addr, `SGD_OFF_RSVD_B);

	assign wrClkLow  = regReq.wr & hitClkLow;
	assign wrRoute   = regReq.wr & hitRoute;
	assign wrDir     = regReq.wr & hitDir;
	assign wrRsvdA   = regReq.wr & hitRsvdA;
	assign wrCfg     = regReq.wr & hitCfg;
	assign wrRsvdB   = regReq.wr & hitRsvdB;

	// ----------------------------------------
	// Field views
	// ----------------------------------------
	wire [3:0]  remotePinRouteEn;
	wire [3:0]  localPinLevel;
	wire [3:0]  pinDriveEn;
	wire [3:0]  pinSenseEn;
	wire        passAllLongTypes;
	wire        typeMatchEn;
	wire        passYuv10Types;
	wire        frameValidInvert;
	wire        lineValidInvert;
	wire [5:0]  typeMatchValue;

	// [R05] Routing field
	assign remotePinRouteEn = gpioOutputRouting[`SGD_ROUTE_HI:`SGD_ROUTE_LO];
	// [R06] Level field
	assign localPinLevel    = gpioOutputRouting[`SGD_LEVEL_HI:`SGD_LEVEL_LO];
	// [R07] Driver enables
	assign pinDriveEn       = gpioPinDirection[`SGD_DRIVE_HI:`SGD_DRIVE_LO];
	// [R08] Input enables
	assign pinSenseEn       = gpioPinDirection[`SGD_SENSE_HI:`SGD_SENSE_LO];
	assign passAllLongTypes = videoPortFilterConfig[`SGD_VP_ANY_BIT];
	assign typeMatchEn      = videoPortFilterConfig[`SGD_VP_MATCH_BIT];
	assign passYuv10Types   = videoPortFilterConfig[`SGD_VP_YUV_BIT];
	assign frameValidInvert = videoPortFilterConfig[`SGD_VP_FV_BIT];
	assign lineValidInvert  = videoPortFilterConfig[`SGD_VP_LV_BIT];
	// [R14] Six bit value
	assign typeMatchValue   = videoPortTypeMatch[`SGD_MATCH_HI:0];

	// ----------------------------------------
	// Match value lock
	// ----------------------------------------
	// [R10] Match value locked
	assign wrMatch = regReq.wr & hitMatch & ~typeMatchEn;

	// ----------------------------------------
	// Read selection
	// ----------------------------------------
	assign rdMux = hitClkLow ? i2cClockLowPeriod :
		hitRoute ? gpioOutputRouting :
		hitDir   ? gpioPinDirection :
		hitRsvdA ? {4'h0, reservedSlotA} :
		hitCfg   ? videoPortFilterConfig :
		hitMatch ? videoPortTypeMatch :
		hitRsvdB ? reservedSlotB :
		`SGD_RD_UNMAPPED;

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	// [R04] Low time reset
	always_ff @(posedge clk) begin
		if (!nrst) begin
			i2cClockLowPeriod <= `SGD_RST_CLK_LOW;
		end else if (wrClkLow) begin
			i2cClockLowPeriod <= regReq.wdata;
		end
	end

	// [R05] Routing reset
	always_ff @(posedge clk) begin
		if (!nrst) begin
			gpioOutputRouting <= `SGD_RST_GPIO_ROUTE;
		end else if (wrRoute) begin
			gpioOutputRouting <= regReq.wdata;
		end
	end

	// [R07] [R08] Direction reset
	always_ff @(posedge clk) begin
		if (!nrst) begin
			gpioPinDirection <= `SGD_RST_GPIO_DIR;
		end else if (wrDir) begin
			gpioPinDirection <= regReq.wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			reservedSlotA <= `SGD_RST_RSVD_A;
		end else if (wrRsvdA) begin
			reservedSlotA <= regReq.wdata[`SGD_RSVD_A_HI:0];
		end
	end

	// [R09] Config reset
	always_ff @(posedge clk) begin
		if (!nrst) begin
			videoPortFilterConfig <= `SGD_RST_VP_CFG;
		end else if (wrCfg) begin
			videoPortFilterConfig <= regReq.wdata;
		end
	end

	// [R10] Blocked match write
	always_ff @(posedge clk) begin
		if (!nrst) begin
			videoPortTypeMatch <= `SGD_RST_VP_MATCH;
		end else if (wrMatch) begin
			videoPortTypeMatch <= regReq.wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			reservedSlotB <= `SGD_RST_RSVD_B;
		end else if (wrRsvdB) begin
			reservedSlotB <= regReq.wdata;
		end
	end

	// ----------------------------------------
	// Read answer
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst) begin
			regRdData  <= 8'h00;
			regRdValid <= 1'b0;
		end else begin
			regRdValid <= regReq.rd;
			if (regReq.rd) begin
				regRdData <= rdMux;
			end
		end
	end

	// ----------------------------------------
	// Pin routing
	// ----------------------------------------
	wire [3:0] next_gpioOut;
	wire [3:0] next_gpioOe;
	wire [3:0] next_gpioSense;
	wire [3:0] remoteDrive;
	wire [3:0] localDrive;

	// [R05] Remote source
	assign remoteDrive    = remotePinRouteEn & remoteGpio;
	// [R06] Local source
	assign localDrive     = ~remotePinRouteEn & pinDriveEn & localPinLevel;
	assign next_gpioOut   = remoteDrive | localDrive;
	// [R16] Undriven when idle
	assign next_gpioOe    = remotePinRouteEn | pinDriveEn;
	// [R08] Input gating
	assign next_gpioSense = gpioIn & pinSenseEn;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			gpioOut   <= 4'h0;
			gpioOe    <= 4'h0;
			gpioSense <= 4'h0;
		end else begin
			gpioOut   <= next_gpioOut;
			gpioOe    <= next_gpioOe;
			gpioSense <= next_gpioSense;
		end
	end

	// ----------------------------------------
	// Clock low timing
	// ----------------------------------------
	// [R01] [R02] Controller low
	sgd_low_timer uCtrlLow (
		.clk      (clk),
		.nrst     (nrst),
		.start    (sclLowStart),
		.lowCount (i2cClockLowPeriod),
		.busy     (sclLowBusy),
		.done     (sclLowDone)
	);

	// [R03] Target data setup
	sgd_low_timer uTgtSetup (
		.clk      (clk),
		.nrst     (nrst),
		.start    (sdaSetupStart),
		.lowCount (i2cClockLowPeriod),
		.busy     (sdaSetupBusy),
		.done     (sdaSetupDone)
	);

	// ----------------------------------------
	// Packet filter
	// ----------------------------------------
	// [R09] [R10] [R11] [R12] [R13] Filter
	sgd_pkt_filter uFilter (
		.clk              (clk),
		.nrst             (nrst),
		.pktIn            (pktIn),
		.rate100mhzSel    (rate100mhzSel),
		.frameValidIn     (frameValidIn),
		.lineValidIn      (lineValidIn),
		.passAllLongTypes (passAllLongTypes),
		.typeMatchEn      (typeMatchEn),
		.passYuv10Types   (passYuv10Types),
		.frameValidInvert (frameValidInvert),
		.lineValidInvert  (lineValidInvert),
		.typeMatchValue   (typeMatchValue),
		.pktOut           (pktOut),
		.pktPass          (pktPass),
		.frameValid       (frameValid),
		.lineValid        (lineValid)
	);
endmodule

// file: test/sgd_cfg_bank_properties.sv
// Checker for the configuration bank
`timescale 1ns/1ps
module sgd_cfg_bank_props (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  sgd_pkg::sgd_reg_req_s regReq,
	input  wire logic [7:0]       regRdData,
	input  wire logic             regRdValid,
	input  wire logic             sclLowStart,
	input  wire logic             sclLowBusy,
	input  wire logic             sclLowDone,
	input  wire logic             sdaSetupStart,
	input  wire logic             sdaSetupBusy,
	input  wire logic             sdaSetupDone,
	input  wire logic [3:0]       remoteGpio,
	input  wire logic [3:0]       gpioIn,
	input  wire logic [3:0]       gpioOut,
	input  wire logic [3:0]       gpioOe,
	input  wire logic [3:0]       gpioSense,
	input  sgd_pkg::sgd_pkt_s     pktIn,
	input  wire logic             rate100mhzSel,
	input  wire logic             frameValidIn,
	input  wire logic             lineValidIn,
	input  sgd_pkg::sgd_pkt_s     pktOut,
	input  wire logic             pktPass,
	input  wire logic             frameValid,
	input  wire logic             lineValid
);
	// ----
	// Register mirror
	// ----
	logic [7:0] lowM, routeM, dirM, cfgM, matchM, rsvBM, lowA, lowB;
	logic [3:0] rsvAM;
	logic [8:0] runA, runB;
	wire  [7:0] adr = regReq.addr;
	wire  [5:0] dt = pktIn.dataType;
	wire  [3:0] expOe = routeM[7:4] | dirM[7:4];
	wire  [3:0] expOut = (routeM[7:4] & remoteGpio) | (~routeM[7:4] & dirM[7:4] & routeM[3:0]);
	wire  [3:0] expSense = gpioIn & dirM[3:0];
	wire        expFv = frameValidIn ^ cfgM[1];
	wire        expLv = lineValidIn ^ cfgM[0];
	wire        expPass = pktIn.valid & ((cfgM[4] & (dt[5] | dt[4]))
		| (cfgM[3] & (matchM[5] | matchM[4]) & (dt == matchM[5:0]))
		| (cfgM[2] & rate100mhzSel & (dt == 6'h19 | dt == 6'h1D | dt == 6'h1F)));
	wire  [7:0] expRd = adr == 8'h0C ? lowM : adr == 8'h0D ? routeM : adr == 8'h0E ? dirM
		: adr == 8'h0F ? {4'h0, rsvAM} : adr == 8'h10 ? cfgM : adr == 8'h11 ? matchM
		: adr == 8'h12 ? rsvBM : 8'h00;
	always_ff @(posedge clk) begin
		if (!nrst) begin
			lowM <= 8'h7F;
			routeM <= 8'hF0;
			dirM <= 8'h0F;
			rsvAM <= 4'h0;
			cfgM <= 8'h00;
			matchM <= 8'h00;
			rsvBM <= 8'h00;
		end else if (regReq.wr) begin
			case (adr)
				8'h0C: lowM <= regReq.wdata;
				8'h0D: routeM <= regReq.wdata;
				8'h0E: dirM <= regReq.wdata;
				8'h0F: rsvAM <= regReq.wdata[3:0];
				8'h10: cfgM <= regReq.wdata;
				8'h11: matchM <= cfgM[3] ? matchM : regReq.wdata;
				8'h12: rsvBM <= regReq.wdata;
				default: ;
			endcase
		end
	end
	always_ff @(posedge clk) begin
		runA <= sclLowBusy ? runA + 9'h001 : 9'h000;
		runB <= sdaSetupBusy ? runB + 9'h001 : 9'h000;
		lowA <= (sclLowStart && !sclLowBusy) ? lowM : lowA;
		lowB <= (sdaSetupStart && !sdaSetupBusy) ? lowM : lowB;
	end
	// ----
	// Properties
	// ----
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence s_startA;
		sclLowStart && !sclLowBusy;
	endsequence
	sequence s_endA;
		$past(nrst) && $fell(sclLowBusy);
	endsequence
	a_timer_start: assert property (
		s_startA |=> sclLowBusy && !sclLowDone) else $error("low timer did not start");
	a_low_length: assert property (
		s_endA |-> sclLowDone && runA == {1'b0, lowA} + 9'h005) else $error("low length wrong");
	a_setup_length: assert property (
		$past(nrst) && $fell(sdaSetupBusy) |-> sdaSetupDone && runB == {1'b0, lowB} + 9'h005)
		else $error("setup length wrong");
	a_read_data: assert property (
		$past(nrst) |-> regRdValid == $past(regReq.rd) && (!regRdValid || regRdData == $past(expRd)))
		else $error("read data wrong");
	a_pin_drive: assert property (
		$past(nrst) |-> gpioOe == $past(expOe)) else $error("pin enable wrong");
	a_pin_level: assert property (
		$past(nrst) |-> gpioOut == $past(expOut)) else $error("pin level wrong");
	a_pin_sense: assert property (
		$past(nrst) |-> gpioSense == $past(expSense)) else $error("pin sense wrong");
	a_pkt_pass: assert property (
		$past(nrst) |-> pktPass == $past(expPass) && pktOut == $past(pktIn))
		else $error("packet pass wrong");
	a_sync_polarity: assert property (
		$past(nrst) |-> frameValid == $past(expFv) && lineValid == $past(expLv))
		else $error("sync polarity wrong");
endmodule

bind sgd_cfg_bank sgd_cfg_bank_props u_props (.clk(clk), .nrst(nrst), .regReq(regReq),
	.regRdData(regRdData), .regRdValid(regRdValid), .sclLowStart(sclLowStart),
	.sclLowBusy(sclLowBusy), .sclLowDone(sclLowDone), .sdaSetupStart(sdaSetupStart),
	.sdaSetupBusy(sdaSetupBusy), .sdaSetupDone(sdaSetupDone), .remoteGpio(remoteGpio),
	.gpioIn(gpioIn), .gpioOut(gpioOut), .gpioOe(gpioOe), .gpioSense(gpioSense),
	.pktIn(pktIn), .rate100mhzSel(rate100mhzSel), .frameValidIn(frameValidIn),
	.lineValidIn(lineValidIn), .pktOut(pktOut), .pktPass(pktPass),
	.frameValid(frameValid), .lineValid(lineValid));

// file: test/sgd_far_side.sv
// Far side model: remote pin source and pulled-up board pins
`timescale 1ns/1ps
module sgd_far_side (
	input  wire logic       clk,
	input  wire logic [3:0] remoteSet,
	input  wire logic [3:0] gpioOut,
	input  wire logic [3:0] gpioOe,
	output logic      [3:0] remoteGpio,
	output logic      [3:0] gpioIn
);
	// Remote pin data arrives registered
	always_ff @(posedge clk) begin
		remoteGpio <= remoteSet;
	end
	// Undriven pins float up to the pull-up
	assign gpioIn = (gpioOe & gpioOut) | ~gpioOe;
endmodule

// file: test/sgd_cfg_bank_tb_top.sv
// Testbench for the configuration bank
`timescale 1ns/1ps
module sgd_cfg_bank_tb_top;
	logic                  clk, nrst, regRdValid, sclLowStart, sclLowBusy, sclLowDone;
	logic                  sdaSetupStart, sdaSetupBusy, sdaSetupDone, rate100, fvIn, lvIn;
	logic                  pktPass, frameValid, lineValid;
	logic [7:0]            regRdData;
	logic [3:0]            remoteSet, remoteGpio, gpioIn, gpioOut, gpioOe, gpioSense;
	sgd_pkg::sgd_reg_req_s regReq;
	sgd_pkg::sgd_pkt_s     pktIn, pktOut;
	int                    nFail, checksDone, n;
	logic [7:0]            rv [8] = '{8'h7F, 8'hF0, 8'h0F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [23:0]           flt [12] = '{{8'h10, 8'h00, 1'b0, 6'h2A, 1'b1},
		{8'h10, 8'h00, 1'b0, 6'h0F, 1'b0}, {8'h08, 8'h2C, 1'b1, 6'h2C, 1'b1},
		{8'h08, 8'h2C, 1'b0, 6'h2C, 1'b1}, {8'h08, 8'h2C, 1'b1, 6'h2D, 1'b0},
		{8'h08, 8'h0C, 1'b0, 6'h0C, 1'b0}, {8'h04, 8'h00, 1'b1, 6'h19, 1'b1},
		{8'h04, 8'h00, 1'b1, 6'h1D, 1'b1}, {8'h04, 8'h00, 1'b1, 6'h1F, 1'b1},
		{8'h04, 8'h00, 1'b0, 6'h19, 1'b0}, {8'h04, 8'h00, 1'b1, 6'h1E, 1'b0},
		{8'h00, 8'h00, 1'b1, 6'h2A, 1'b0}};

	sgd_cfg_bank uut (.clk(clk), .nrst(nrst), .regReq(regReq), .regRdData(regRdData),
		.regRdValid(regRdValid), .sclLowStart(sclLowStart), .sclLowBusy(sclLowBusy),
		.sclLowDone(sclLowDone), .sdaSetupStart(sdaSetupStart), .sdaSetupBusy(sdaSetupBusy),
		.sdaSetupDone(sdaSetupDone), .remoteGpio(remoteGpio), .gpioIn(gpioIn),
		.gpioOut(gpioOut), .gpioOe(gpioOe), .gpioSense(gpioSense), .pktIn(pktIn),
		.rate100mhzSel(rate100), .rate75mhzSel(~rate100), .frameValidIn(fvIn),
		.lineValidIn(lvIn), .pktOut(pktOut), .pktPass(pktPass), .frameValid(frameValid),
		.lineValid(lineValid));
	sgd_far_side u_far (.clk(clk), .remoteSet(remoteSet), .gpioOut(gpioOut),
		.gpioOe(gpioOe), .remoteGpio(remoteGpio), .gpioIn(gpioIn));

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		checksDone++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", what, exp, got);
			nFail++;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) regReq <= '{1'b1, 1'b0, a, d};
		@(posedge clk) regReq <= '0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk) regReq <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk) regReq <= '0;
		#1;
		check("regRdValid", 8'h01, {7'h00, regRdValid});
		check("regRdData", exp, regRdData);
	endtask
	task automatic tmr(input logic sel, input logic [7:0] exp);
		@(posedge clk) {sdaSetupStart, sclLowStart} <= sel ? 2'b10 : 2'b01;
		@(posedge clk) {sdaSetupStart, sclLowStart} <= 2'b00;
		n = 0;
		repeat (300) begin
			#1;
			if (sel ? sdaSetupDone : sclLowDone) break;
			if (sel ? sdaSetupBusy : sclLowBusy) n++;
			@(posedge clk);
		end
		check("busy cycles", exp, 8'(n));
	endtask
	task automatic pins(input logic [3:0] oe, input logic [3:0] out, input logic [3:0] sns);
		repeat (2) @(posedge clk);
		#1;
		check("gpioOe", {4'h0, oe}, {4'h0, gpioOe});
		check("gpioOut", {4'h0, out}, {4'h0, gpioOut});
		check("gpioSense", {4'h0, sns}, {4'h0, gpioSense});
	endtask
	task automatic pkt(input logic [5:0] dt, input logic exp);
		@(posedge clk) pktIn <= '{1'b1, dt};
		@(posedge clk) pktIn <= '0;
		#1;
		check("pktPass", {7'h00, exp}, {7'h00, pktPass});
		check("pktOut", {2'b01, dt}, {1'b0, pktOut});
	endtask
	task automatic endSim();
		$display("Checks %0d mismatches %0d", checksDone, nFail);
		if (nFail == 0 && checksDone > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		nFail++;
		endSim();
	end
	initial begin
		nrst = 1'b0;
		regReq = '0;
		pktIn = '0;
		remoteSet = 4'hA;
		{rate100, fvIn, lvIn, sclLowStart, sdaSetupStart} = 5'b01100;
		nFail = 0;
		checksDone = 0;
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			rd(i == 7 ? 8'h20 : 8'h0C + 8'(i), rv[i]);
		end
		pins(4'hF, 4'hA, 4'hA);
		@(posedge clk) remoteSet <= 4'h5;
		@(posedge clk);
		pins(4'hF, 4'h5, 4'h5);
		@(posedge clk) remoteSet <= 4'hA;
		tmr(1'b0, 8'h84);
		wr(8'h0C, 8'h00);
		tmr(1'b0, 8'h05);
		wr(8'h0C, 8'h03);
		tmr(1'b1, 8'h08);
		wr(8'h0F, 8'hFF);
		wr(8'h20, 8'h55);
		rd(8'h0F, 8'h0F);
		rd(8'h20, 8'h00);
		wr(8'h0E, 8'h3A);
		wr(8'h0D, 8'h05);
		pins(4'h3, 4'h1, 4'h8);
		wr(8'h0D, 8'h85);
		pins(4'hB, 4'h9, 4'h8);
		for (int i = 0; i < 12; i++) begin
			wr(8'h10, 8'h00);
			wr(8'h11, flt[i][15:8]);
			wr(8'h10, flt[i][23:16]);
			rate100 <= flt[i][7];
			pkt(flt[i][6:1], flt[i][0]);
		end
		wr(8'h10, 8'h08);
		wr(8'h11, 8'h3F);
		rd(8'h11, 8'h00);
		wr(8'h10, 8'h00);
		wr(8'h11, 8'h3F);
		rd(8'h11, 8'h3F);
		for (int i = 0; i < 8; i++) begin
			wr(8'h10, 8'(i[1:0]));
			fvIn <= i[2];
			lvIn <= ~i[2];
			repeat (2) @(posedge clk);
			#1;
			check("frameValid", {7'h00, i[2] ^ i[1]}, {7'h00, frameValid});
			check("lineValid", {7'h00, ~i[2] ^ i[0]}, {7'h00, lineValid});
		end
		wr(8'h0C, 8'h10);
		wr(8'h10, 8'h08);
		@(posedge clk) nrst <= 1'b0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		rd(8'h0C, 8'h7F);
		rd(8'h10, 8'h00);
		wr(8'h11, 8'h2C);
		rd(8'h11, 8'h2C);
		pins(4'hF, 4'hA, 4'hA);
		endSim();
	end
endmodule
